// [design/svtc_checker.sv]
// variable descriptor table checker and component exchange sequencer
// ==========================================================
// Overview of operation
// - read table: count word 0, spare word 1, result base word 2, then pairs
// - read exactly the first N variables, N being the bcd count 1..12
// - read count not bcd 1..12 gives syntax error and no read
// - read table word 2 is the bcd result area address 0..9999
// - type word of variable n sits at offset 1 plus 2n
// - address word of variable n sits at 2 plus 2n, passed on unchanged
// - only type codes C0..CF are accepted, else syntax error
// - write table: count word 0, command gate word 1, source base word 2
// - send the first N write variables, N being the bcd count 0..12
// - zero write count sends no variables, only the gated command
// - write count not bcd 0..12 gives syntax error and no write
// - forward the operation command only when the gate word is 1
// - gate word other than 0 or 1 is a syntax error
// - write table word 2 locates command and values to send
// - result area: monitor, component status, then low and high halves
// - after a link error the failing and later results are zero
//
// Strobed register access is this design's own decision.
module svtc_checker
  import svtc_pkg::*;
(
  input  logic                  clk,
  input  logic                  nrst,
  input  logic                  ce,
  input  svtc_pkg::svtc_raddr_t regAddr,
  input  svtc_pkg::svtc_word_t  regWdata,
  input  logic                  regWr,
  input  logic                  regRd,
  output svtc_pkg::svtc_word_t  regRdata,
  output svtc_pkg::svtc_maddr_t memAddr,
  output svtc_pkg::svtc_word_t  memWdata,
  output logic                  memWr,
  output logic                  memRd,
  input  svtc_pkg::svtc_word_t  memRdata,
  output svtc_pkg::svtc_req_t   linkReq,
  output logic                  linkReqValid,
  input  svtc_pkg::svtc_rsp_t   linkRsp,
  input  logic                  linkRspValid,
  output logic                  irq,
  output logic                  busy
);
  import svtc_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE, ST_R_SEND, ST_R_WAIT, ST_R_LO, ST_R_HI, ST_R_ZLO, ST_R_ZHI, ST_R_MON, ST_R_CST,
    ST_W_OPRD, ST_W_OPWT, ST_W_OPCAP, ST_W_FLO, ST_W_FHI, ST_W_CLO, ST_W_CHI, ST_W_WAIT, ST_W_MON
  } svtc_state_t;

  svtc_state_t          state_ff;
  svtc_state_t          nxt_state;
  svtc_word_t           readTbl_ff  [TBL_WORDS];
  svtc_word_t           writeTbl_ff [TBL_WORDS];
  svtc_idx_t            varIdx_ff;
  svtc_idx_t            nxt_varIdx;
  logic                 opDone_ff;
  svtc_rsp_t            rspBuf_ff;
  svtc_word_t           dataLo_ff;
  logic [EV_BITS-1:0]   irqStat_ff;
  logic [EV_BITS-1:0]   irqMask_ff;
  logic [EV_BITS-1:0]   evSet;
  logic                 rdSynErr;
  logic                 wrSynErr;
  logic                 rdBaseBcd;
  logic                 wrBaseBcd;
  svtc_idx_t            rdCount;
  svtc_idx_t            wrCount;
  svtc_maddr_t          rdBase;
  svtc_maddr_t          wrBase;
  svtc_maddr_t          pairAddr;
  svtc_toff_t           typeOff;
  svtc_toff_t           addrOff;
  logic                 rdGo;
  logic                 wrGo;
  logic                 rdBad;
  logic                 wrBad;
  logic                 lastVar;
  logic                 rspErr;
  logic                 rdTblHit;
  logic                 wrTblHit;
  svtc_raddr_t          wrTblIdx;

  // ==========================================================
  // table checks
  svtc_table_check #(.IS_READ(1'b1)) u_rdCheck (
    .tbl       (readTbl_ff),
    .syntaxErr (rdSynErr),
    .count     (rdCount)
  );
  svtc_table_check #(.IS_READ(1'b0)) u_wrCheck (
    .tbl       (writeTbl_ff),
    .syntaxErr (wrSynErr),
    .count     (wrCount)
  );
  svtc_bcd_word u_rdBase (
    .bcdIn  (readTbl_ff[OFF_BASE]),
    .isBcd  (rdBaseBcd),
    .binOut (rdBase)
  );
  svtc_bcd_word u_wrBase (
    .bcdIn  (writeTbl_ff[OFF_BASE]),
    .isBcd  (wrBaseBcd),
    .binOut (wrBase)
  );

  // ==========================================================
  // decode
  always_comb begin
    wrTblIdx = regAddr - WTBL_BASE;
    rdTblHit = regAddr < svtc_raddr_t'(TBL_WORDS);
    wrTblHit = (regAddr >= WTBL_BASE) && (wrTblIdx < svtc_raddr_t'(TBL_WORDS));
    rdGo     = regWr && (regAddr == REG_CTRL) && regWdata[CTRL_RD_GO] && (state_ff == ST_IDLE);
    wrGo     = regWr && (regAddr == REG_CTRL) && regWdata[CTRL_WR_GO] && (state_ff == ST_IDLE) && !rdGo;
    rdBad    = rdSynErr || !rdBaseBcd;
    wrBad    = wrSynErr || !wrBaseBcd;
    typeOff  = OFF_TYPE1 + svtc_toff_t'({varIdx_ff, 1'b0});
    addrOff  = OFF_ADDR1 + svtc_toff_t'({varIdx_ff, 1'b0});
    pairAddr = AREA_DAT1 + svtc_maddr_t'({varIdx_ff, 1'b0});
    lastVar  = (4'(varIdx_ff + 4'h1) >= ((state_ff < ST_W_OPRD) ? rdCount : wrCount));
    rspErr   = linkRsp.code != RESP_OK;
  end

  // ==========================================================
  // sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_varIdx = varIdx_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_varIdx = 4'h0;
        if (rdGo && !rdBad) begin
          nxt_state = ST_R_SEND;
        end else if (wrGo && !wrBad) begin
          if (writeTbl_ff[OFF_CTRLW] == GATE_ON) begin
            nxt_state = ST_W_OPRD;
          end else if (wrCount != 4'h0) begin
            nxt_state = ST_W_FLO;
          end else begin
            nxt_state = ST_W_MON;
          end
        end
      end
      ST_R_SEND:  nxt_state = ST_R_WAIT;
      ST_R_WAIT:  if (linkRspValid) nxt_state = rspErr ? ST_R_ZLO : ST_R_LO;
      ST_R_LO:    nxt_state = ST_R_HI;
      ST_R_HI: begin
        nxt_varIdx = 4'(varIdx_ff + 4'h1);
        nxt_state  = lastVar ? ST_R_MON : ST_R_SEND;
      end
      ST_R_ZLO:   nxt_state = ST_R_ZHI;
      ST_R_ZHI: begin
        nxt_varIdx = 4'(varIdx_ff + 4'h1);
        nxt_state  = lastVar ? ST_R_MON : ST_R_ZLO;
      end
      ST_R_MON:   nxt_state = ST_R_CST;
      ST_R_CST:   nxt_state = ST_IDLE;
      ST_W_OPRD:  nxt_state = ST_W_OPWT;
      ST_W_OPWT:  nxt_state = ST_W_OPCAP;
      ST_W_OPCAP: nxt_state = ST_W_WAIT;
      ST_W_FLO:   nxt_state = ST_W_FHI;
      ST_W_FHI:   nxt_state = ST_W_CLO;
      ST_W_CLO:   nxt_state = ST_W_CHI;
      ST_W_CHI:   nxt_state = ST_W_WAIT;
      ST_W_WAIT: begin
        if (linkRspValid) begin
          if (!opDone_ff) begin
            nxt_state = (rspErr || wrCount == 4'h0) ? ST_W_MON : ST_W_FLO;
          end else begin
            nxt_varIdx = 4'(varIdx_ff + 4'h1);
            nxt_state  = (rspErr || lastVar) ? ST_W_MON : ST_W_FLO;
          end
        end
      end
      ST_W_MON:   nxt_state = ST_IDLE;
      default:    nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= ST_IDLE;
      varIdx_ff <= 4'h0;
    end else if (ce) begin
      state_ff  <= nxt_state;
      varIdx_ff <= nxt_varIdx;
    end
  end

  // operation command goes first, so a count of zero still reaches it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opDone_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == ST_IDLE) begin
        opDone_ff <= writeTbl_ff[OFF_CTRLW] != GATE_ON;
      end else if (state_ff == ST_W_WAIT && linkRspValid) begin
        opDone_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // link side
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkReq      <= '0;
      linkReqValid <= 1'b0;
      rspBuf_ff    <= '0;
      dataLo_ff    <= ZERO_WORD;
    end else if (ce) begin
      linkReqValid <= 1'b0;
      if (state_ff == ST_R_SEND) begin
        linkReqValid    <= 1'b1;
        linkReq         <= '0;
        linkReq.varType <= readTbl_ff[typeOff][7:0];
        linkReq.varAddr <= readTbl_ff[addrOff];
      end else if (state_ff == ST_W_OPCAP) begin
        linkReqValid       <= 1'b1;
        linkReq            <= '0;
        linkReq.isWrite    <= 1'b1;
        linkReq.opCmd      <= 1'b1;
        linkReq.data[15:0] <= memRdata;
      end else if (state_ff == ST_W_CHI) begin
        linkReqValid    <= 1'b1;
        linkReq.isWrite <= 1'b1;
        linkReq.opCmd   <= 1'b0;
        linkReq.varType <= writeTbl_ff[typeOff][7:0];
        linkReq.varAddr <= writeTbl_ff[addrOff];
        linkReq.data    <= {memRdata, dataLo_ff};
      end
      if (state_ff == ST_W_CLO) begin
        dataLo_ff <= memRdata;
      end
      if ((state_ff == ST_R_WAIT || state_ff == ST_W_WAIT) && linkRspValid) begin
        rspBuf_ff <= linkRsp;
      end
    end
  end

  // ==========================================================
  // word memory side
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memAddr  <= '0;
      memWdata <= ZERO_WORD;
      memWr    <= 1'b0;
      memRd    <= 1'b0;
    end else if (ce) begin
      memWr <= 1'b0;
      memRd <= 1'b0;
      case (state_ff)
        ST_R_LO, ST_R_ZLO: begin
          memWr    <= 1'b1;
          memAddr  <= rdBase + pairAddr;
          memWdata <= (state_ff == ST_R_LO) ? rspBuf_ff.data[15:0] : ZERO_WORD;
        end
        ST_R_HI, ST_R_ZHI: begin
          memWr    <= 1'b1;
          memAddr  <= 14'(rdBase + pairAddr + 14'h0001);
          memWdata <= (state_ff == ST_R_HI) ? rspBuf_ff.data[31:16] : ZERO_WORD;
        end
        ST_R_MON, ST_W_MON: begin
          memWr    <= 1'b1;
          memAddr  <= ((state_ff == ST_R_MON) ? rdBase : wrBase) + AREA_MON;
          memWdata <= rspBuf_ff.code;
        end
        ST_R_CST: begin
          memWr    <= 1'b1;
          memAddr  <= rdBase + AREA_SEC;
          memWdata <= rspBuf_ff.compStatus;
        end
        ST_W_OPRD: begin
          memRd   <= 1'b1;
          memAddr <= wrBase + AREA_SEC;
        end
        ST_W_FLO: begin
          memRd   <= 1'b1;
          memAddr <= wrBase + pairAddr;
        end
        ST_W_FHI: begin
          memRd   <= 1'b1;
          memAddr <= 14'(wrBase + pairAddr + 14'h0001);
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // register file
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < TBL_WORDS; i++) begin
        readTbl_ff[i]  <= ZERO_WORD;
        writeTbl_ff[i] <= ZERO_WORD;
      end
    end else if (ce && regWr) begin
      if (rdTblHit) readTbl_ff[regAddr[4:0]] <= regWdata;
      if (wrTblHit) writeTbl_ff[wrTblIdx[4:0]] <= regWdata;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_comb begin
    evSet             = '0;
    evSet[EV_RD_DONE] = state_ff == ST_R_CST;
    evSet[EV_WR_DONE] = state_ff == ST_W_MON;
    evSet[EV_SYNTAX]  = (rdGo && rdBad) || (wrGo && wrBad);
    evSet[EV_COMM]    = (state_ff == ST_R_CST || state_ff == ST_W_MON) && rspBuf_ff.code != RESP_OK;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_ff <= '0;
      irqMask_ff <= '0;
      irq        <= 1'b0;
      busy       <= 1'b0;
    end else if (ce) begin
      irqStat_ff <= (irqStat_ff & ~((regWr && regAddr == REG_IRQ_STAT) ? regWdata[EV_BITS-1:0] : '0)) | evSet;
      if (regWr && regAddr == REG_IRQ_MASK) irqMask_ff <= regWdata[EV_BITS-1:0];
      irq  <= |(irqStat_ff & irqMask_ff);
      busy <= nxt_state != ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= ZERO_WORD;
    end else if (ce) begin
      regRdata <= ZERO_WORD;
      if (regRd) begin
        if (rdTblHit) regRdata <= readTbl_ff[regAddr[4:0]];
        else if (wrTblHit) regRdata <= writeTbl_ff[wrTblIdx[4:0]];
        else if (regAddr == REG_STATUS) begin
          regRdata[ST_BUSY]   <= state_ff != ST_IDLE;
          regRdata[ST_RD_SYN] <= rdBad;
          regRdata[ST_WR_SYN] <= wrBad;
        end
        else if (regAddr == REG_IRQ_STAT) regRdata[EV_BITS-1:0] <= irqStat_ff;
        else if (regAddr == REG_IRQ_MASK) regRdata[EV_BITS-1:0] <= irqMask_ff;
        else if (regAddr == REG_RESP) regRdata <= rspBuf_ff.code;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (!nrst);

  sequence s_rsp_ok;
    state_ff == ST_R_WAIT && linkRspValid && linkRsp.code == RESP_OK;
  endsequence
  sequence s_low_stored(logic [15:0] d);
    memWr && memWdata == d;
  endsequence

  a_read_blocked: assert property (rdGo && rdBad |=> state_ff == ST_IDLE ##1 !linkReqValid)
    else $error("read frame started despite syntax error");
  a_write_blocked: assert property (wrGo && wrBad |=> state_ff == ST_IDLE ##1 !linkReqValid)
    else $error("write frame started despite syntax error");
  a_type_range: assert property (linkReqValid && !linkReq.opCmd |->
      linkReq.varType >= TYPE_MIN && linkReq.varType <= TYPE_MAX)
    else $error("variable type outside accepted range");
  a_addr_passed: assert property (state_ff == ST_R_SEND |=>
      linkReqValid && linkReq.varAddr == $past(readTbl_ff[addrOff]))
    else $error("variable address not passed unchanged");
  a_result_low: assert property (s_rsp_ok |-> ##2 s_low_stored($past(linkRsp.data[15:0], 2)))
    else $error("read result low half not stored");
  a_zero_fill: assert property (state_ff == ST_R_ZLO |=> s_low_stored(ZERO_WORD)
      ##1 s_low_stored(ZERO_WORD))
    else $error("failing result not zeroed");
  a_op_gated: assert property (linkReqValid && linkReq.opCmd |->
      $past(writeTbl_ff[OFF_CTRLW], 4) == GATE_ON)
    else $error("operation command sent with gate off");
  a_monitor_place: assert property (state_ff == ST_R_MON |=>
      memWr && memAddr == $past(rdBase) && memWdata == $past(rspBuf_ff.code))
    else $error("response monitor not at result base");
  a_count_bound: assert property (linkReqValid && !linkReq.opCmd |->
      $past(varIdx_ff) < (linkReq.isWrite ? wrCount : rdCount))
    else $error("more variables sent than counted");
endmodule : svtc_checker

// [shared/svtc_pkg.sv]
// package: constants, register map and link carriers for the variable table checker
package svtc_pkg;
  // ==========================================================
  // table geometry
  localparam int TBL_WORDS = 27;
  localparam int MAX_ITEMS = 12;
  localparam int PAIR_STEP = 2;

  typedef logic [15:0] svtc_word_t;
  typedef logic [13:0] svtc_maddr_t;
  typedef logic [7:0]  svtc_raddr_t;
  typedef logic [3:0]  svtc_idx_t;
  typedef logic [4:0]  svtc_toff_t;

  localparam svtc_toff_t  OFF_COUNT = 5'h00;
  localparam svtc_toff_t  OFF_CTRLW = 5'h01;
  localparam svtc_toff_t  OFF_BASE  = 5'h02;
  localparam svtc_toff_t  OFF_TYPE1 = 5'h03;
  localparam svtc_toff_t  OFF_ADDR1 = 5'h04;
  localparam svtc_maddr_t AREA_MON  = 14'h0000;
  localparam svtc_maddr_t AREA_SEC  = 14'h0001;
  localparam svtc_maddr_t AREA_DAT1 = 14'h0002;

  // ==========================================================
  // value ranges
  localparam logic [7:0] TYPE_MIN  = 8'hC0;
  localparam logic [7:0] TYPE_MAX  = 8'hCF;
  localparam logic [3:0] BCD_NINE  = 4'h9;
  localparam logic [3:0] TENS_MAX  = 4'h1;
  localparam logic [3:0] UNITS_TOP = 4'h2;
  localparam logic [3:0] TEN_BIN   = 4'hA;
  localparam svtc_word_t GATE_OFF  = 16'h0000;
  localparam svtc_word_t GATE_ON   = 16'h0001;
  localparam svtc_word_t RESP_OK   = 16'h0000;
  localparam svtc_word_t ZERO_WORD = 16'h0000;

  // ==========================================================
  // register map
  localparam svtc_raddr_t RTBL_BASE    = 8'h00;
  localparam svtc_raddr_t WTBL_BASE    = 8'h20;
  localparam svtc_raddr_t REG_CTRL     = 8'h40;
  localparam svtc_raddr_t REG_STATUS   = 8'h41;
  localparam svtc_raddr_t REG_IRQ_STAT = 8'h42;
  localparam svtc_raddr_t REG_IRQ_MASK = 8'h43;
  localparam svtc_raddr_t REG_RESP     = 8'h44;
  localparam int CTRL_RD_GO = 0;
  localparam int CTRL_WR_GO = 1;
  localparam int EV_RD_DONE = 0;
  localparam int EV_WR_DONE = 1;
  localparam int EV_SYNTAX  = 2;
  localparam int EV_COMM    = 3;
  localparam int EV_BITS    = 4;
  localparam int ST_BUSY    = 0;
  localparam int ST_RD_SYN  = 1;
  localparam int ST_WR_SYN  = 2;

  // ==========================================================
  // link carriers
  typedef struct packed {
    logic        isWrite;
    logic        opCmd;
    logic [7:0]  varType;
    svtc_word_t  varAddr;
    logic [31:0] data;
  } svtc_req_t;

  typedef struct packed {
    svtc_word_t  code;
    svtc_word_t  compStatus;
    logic [31:0] data;
  } svtc_rsp_t;
endpackage : svtc_pkg

// [design/svtc_bcd_word.sv]
// four-digit bcd word check and conversion to a binary word-memory address
module svtc_bcd_word
  import svtc_pkg::*;
(
  input  svtc_pkg::svtc_word_t  bcdIn,
  output logic                  isBcd,
  output svtc_pkg::svtc_maddr_t binOut
);
  // ==========================================================
  // digit check and weighting
  always_comb begin
    isBcd  = (bcdIn[15:12] <= BCD_NINE) && (bcdIn[11:8] <= BCD_NINE) &&
             (bcdIn[7:4] <= BCD_NINE) && (bcdIn[3:0] <= BCD_NINE);
    binOut = 14'(14'(bcdIn[15:12]) * 14'h3E8 + 14'(bcdIn[11:8]) * 14'h064 +
                 14'(bcdIn[7:4]) * 14'h00A + 14'(bcdIn[3:0]));
  end
endmodule : svtc_bcd_word

// [design/svtc_table_check.sv]
// syntax check of one descriptor table: item count, control word, variable types
module svtc_table_check
  import svtc_pkg::*;
#(
  parameter bit IS_READ = 1'b1
)
(
  input  svtc_pkg::svtc_word_t tbl [svtc_pkg::TBL_WORDS],
  output logic                 syntaxErr,
  output svtc_pkg::svtc_idx_t  count
);
  logic [MAX_ITEMS-1:0] typeOk;
  logic                 countOk;
  logic                 ctrlOk;
  svtc_word_t           cw;

  // ==========================================================
  // count and control word
  always_comb begin
    cw      = tbl[OFF_COUNT];
    countOk = (cw[15:8] == 8'h00) &&
              (((cw[7:4] == 4'h0) && (cw[3:0] <= BCD_NINE) && ((cw[3:0] != 4'h0) || !IS_READ)) ||
               ((cw[7:4] == TENS_MAX) && (cw[3:0] <= UNITS_TOP)));
    count   = (cw[7:4] == TENS_MAX) ? 4'(TEN_BIN + cw[3:0]) : cw[3:0];
    ctrlOk  = IS_READ || (tbl[OFF_CTRLW] == GATE_OFF) || (tbl[OFF_CTRLW] == GATE_ON);
  end

  // ==========================================================
  // only the used pairs are checked
  for (genvar i = 0; i < MAX_ITEMS; i++) begin : g_type
    assign typeOk[i] = (svtc_idx_t'(i) >= count) ||
                       ((tbl[int'(OFF_TYPE1) + PAIR_STEP * i] >= {8'h00, TYPE_MIN}) &&
                        (tbl[int'(OFF_TYPE1) + PAIR_STEP * i] <= {8'h00, TYPE_MAX}));
  end

  assign syntaxErr = !countOk || !ctrlOk || !(&typeOk);
endmodule : svtc_table_check

// [tb/svtc_partner.sv]
// far-side instrument model: answers each request after a programmable delay
module svtc_partner
  import svtc_pkg::*;
(
  input  logic                 clk,
  input  logic                 nrst,
  input  svtc_pkg::svtc_req_t  linkReq,
  input  logic                 linkReqValid,
  input  logic [3:0]           dly,
  input  logic [3:0]           errAt,
  input  svtc_pkg::svtc_word_t errCode,
  output svtc_pkg::svtc_rsp_t  linkRsp,
  output logic                 linkRspValid
);
  timeunit 1ns;
  timeprecision 1ps;
  svtc_req_t  reqQ [$];
  logic       pend_ff;
  logic [3:0] cnt_ff;
  // ==========================================================
  // responder
  // idle response lines toggle so a stale answer is never taken for data
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
      cnt_ff <= 4'h0;
      linkRspValid <= 1'b0;
      linkRsp <= '0;
    end else begin
      linkRspValid <= 1'b0;
      if (linkReqValid) begin
        reqQ.push_back(linkReq);
        pend_ff <= 1'b1;
        cnt_ff <= dly;
      end else if (pend_ff && cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else if (pend_ff) begin
        pend_ff <= 1'b0;
        linkRspValid <= 1'b1;
        linkRsp.code <= (reqQ.size() == int'(errAt)) ? errCode : RESP_OK;
        linkRsp.compStatus <= 16'h0042;
        linkRsp.data <= {reqQ[$].varAddr, 8'h00, reqQ[$].varType};
      end else begin
        linkRsp <= ~linkRsp;
      end
    end
  end
endmodule : svtc_partner

// [tb/tb_svtc_checker.sv]
// self-checking bench for the variable table checker
module tb_svtc_checker;
  timeunit 1ns;
  timeprecision 1ps;
  import svtc_pkg::*;
  // ==========================================================
  // signals and models
  logic        clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, memWr, memRd, linkReqValid, linkRspValid, irq, busy;
  svtc_raddr_t regAddr = '0;
  svtc_word_t  regWdata = '0, regRdata, memWdata, memRdata = '0, errCode = '0;
  svtc_maddr_t memAddr;
  svtc_req_t   linkReq;
  svtc_rsp_t   linkRsp;
  logic [3:0]  dly = '0, errAt = '0;
  svtc_word_t  mem [64];
  svtc_word_t  badC [5] = '{16'h0000, 16'h0013, 16'h000A, 16'h0001, 16'h0001};
  int          errTotal = 0, checks = 0;
  always #4 clk = ~clk;
  // word memory: read data valid only in the cycle after the strobe
  always @(posedge clk) begin
    if (memWr)
      mem[memAddr[5:0]] <= memWdata;
    memRdata <= memRd ? mem[memAddr[5:0]] : ~memRdata;
  end
  svtc_checker dut_u (.clk(clk), .nrst(nrst), .ce(1'b1), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .memAddr(memAddr), .memWdata(memWdata), .memWr(memWr), .memRd(memRd),
    .memRdata(memRdata), .linkReq(linkReq), .linkReqValid(linkReqValid), .linkRsp(linkRsp),
    .linkRspValid(linkRspValid), .irq(irq), .busy(busy));
  svtc_partner partner_u (.clk(clk), .nrst(nrst), .linkReq(linkReq), .linkReqValid(linkReqValid), .dly(dly),
    .errAt(errAt), .errCode(errCode), .linkRsp(linkRsp), .linkRspValid(linkRspValid));
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input svtc_word_t e, input svtc_word_t g);
    checks++;
    if (g !== e) begin
      errTotal++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input svtc_raddr_t a, input svtc_word_t d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input svtc_raddr_t a, input svtc_word_t e, input string nm);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(nm, e, regRdata);
  endtask : rd
  task automatic setTbl(input svtc_raddr_t b, input svtc_word_t c, g, base, input int n);
    wr(b, c);
    wr(b + 8'h01, g);
    wr(b + 8'h02, base);
    for (int i = 0; i < n; i++) begin
      wr(b + 8'(3 + 2 * i), 16'h00C0 + 16'(i));
      wr(b + 8'(4 + 2 * i), 16'h0100 + 16'(i));
    end
  endtask : setTbl
  task automatic run(input svtc_word_t go, input int nReq, input svtc_word_t ev);
    partner_u.reqQ.delete();
    wr(REG_CTRL, go);
    repeat (2) @(posedge clk);
    for (int k = 0; k < 3000 && busy !== 1'b0; k++)
      @(posedge clk);
    chk("idle", 16'h0000, {15'h0, busy});
    chk("reqs", 16'(nReq), 16'(partner_u.reqQ.size()));
    rd(REG_IRQ_STAT, ev, "irqStat");
    wr(REG_IRQ_STAT, 16'h000F);
  endtask : run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (60000) @(posedge clk);
    errTotal++;
    summarize();
  end
  // ==========================================================
  // tests
  initial begin
    int n;
    foreach (mem[k]) mem[k] = 16'hDEAD;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(REG_STATUS, 16'h0002, "status");
    rd(RTBL_BASE, 16'h0000, "tblReset");
    rd(8'h50, 16'h0000, "unmapped");
    wr(REG_IRQ_MASK, 16'h000F);
    rd(REG_IRQ_MASK, 16'h000F, "irqMask");
    for (int j = 0; j < 2; j++) begin
      n = j ? 12 : 1;
      setTbl(RTBL_BASE, j ? 16'h0012 : 16'h0001, 16'h0000, 16'h0020, n);
      dly <= j ? 4'h5 : 4'h0;
      run(16'h0001, n, 16'h0001);
      for (int i = 1; i <= n; i++) begin
        chk("lo", 16'h00BF + 16'(i), mem[20 + 2 * i]);
        chk("hi", 16'h00FF + 16'(i), mem[21 + 2 * i]);
      end
      chk("mon", RESP_OK, mem[20]);
      chk("comp", 16'h0042, mem[21]);
    end
    setTbl(RTBL_BASE, 16'h0003, 16'h0000, 16'h0020, 3);
    errAt <= 4'h2;
    errCode <= 16'hFF10;
    run(16'h0001, 2, 16'h0009);
    chk("lo1", 16'h00C0, mem[22]);
    for (int k = 24; k < 28; k++)
      chk("zero", 16'h0000, mem[k]);
    chk("errMon", 16'hFF10, mem[20]);
    rd(REG_RESP, 16'hFF10, "resp");
    errAt <= 4'h0;
    for (int j = 0; j < 5; j++) begin
      setTbl(RTBL_BASE, badC[j], 16'h0000, j == 4 ? 16'h00A0 : 16'h0020, 1);
      if (j == 3)
        wr(RTBL_BASE + 8'h03, 16'h00D0);
      run(16'h0001, 0, 16'h0004);
    end
    rd(REG_STATUS, 16'h0002, "rdBad");
    mem[41] = 16'h0007;
    mem[42] = 16'h1234;
    mem[43] = 16'hABCD;
    setTbl(WTBL_BASE, 16'h0001, 16'h0001, 16'h0040, 1);
    run(16'h0002, 2, 16'h0002);
    chk("op", 16'h0007, partner_u.reqQ[0].data[15:0]);
    chk("opFlag", 16'h0003, {14'h0, partner_u.reqQ[0].isWrite, partner_u.reqQ[0].opCmd});
    chk("wLo", 16'h1234, partner_u.reqQ[1].data[15:0]);
    chk("wHi", 16'hABCD, partner_u.reqQ[1].data[31:16]);
    chk("wAdr", 16'h0100, partner_u.reqQ[1].varAddr);
    chk("wMon", RESP_OK, mem[40]);
    for (int g = 0; g < 2; g++) begin
      setTbl(WTBL_BASE, 16'h0000, 16'(g), 16'h0040, 0);
      run(16'h0002, g, 16'h0002);
    end
    for (int j = 0; j < 4; j++) begin
      setTbl(WTBL_BASE, j == 1 ? 16'h0013 : (j == 2 ? 16'h000A : 16'h0001), j == 0 ? 16'h0002 : 16'h0001,
        16'h0040, 1);
      if (j == 3)
        wr(WTBL_BASE + 8'h03, 16'h00BF);
      run(16'h0002, 0, 16'h0004);
    end
    rd(REG_STATUS, 16'h0006, "wrBad");
    wr(REG_IRQ_MASK, 16'h0000);
    wr(REG_CTRL, 16'h0002);
    repeat (3) @(posedge clk);
    #1;
    chk("irqMasked", 16'h0000, {15'h0, irq});
    wr(REG_IRQ_MASK, 16'h0004);
    repeat (2) @(posedge clk);
    #1;
    chk("irqOn", 16'h0001, {15'h0, irq});
    wr(REG_IRQ_STAT, 16'h0004);
    repeat (2) @(posedge clk);
    #1;
    chk("irqClr", 16'h0000, {15'h0, irq});
    summarize();
  end
endmodule : tb_svtc_checker
